// ### hw/qio_defines.vh
`ifndef QIO_DEFINES_VH
`define QIO_DEFINES_VH
// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define QIO_IDX_CHG_AB 6'h04
`define QIO_IDX_CHG_CD 6'h14
`define QIO_IDX_LATCH_AB 6'h0c
`define QIO_IDX_LATCH_CD 6'h1c
`define QIO_IDX_LVL_AB 6'h0d
`define QIO_IDX_LVL_CD 6'h1d
`define QIO_IDX_SNAP 6'h28
`define QIO_IDX_SNAP_CHAN 6'h29
`define QIO_IDX_REFRESH 6'h2a
`define QIO_IDX_CFG_A 6'h30
`define QIO_IDX_AUX 6'h34
`define QIO_IDX_MODE 6'h35
// ****************************************
// field positions
// ****************************************
`define QIO_CFG_P3 7:6
`define QIO_CFG_P2 5:4
`define QIO_CFG_P1 3:2
`define QIO_CFG_P0 1:0
`define QIO_SNAP_CNT 7:5
`define QIO_SNAP_TYPE 4:2
`define QIO_SNAP_CHAN 1:0
`define QIO_CODE_OFF 2'h0
`define QIO_CODE_GEN 2'h1
`define QIO_CODE_SRC_A 2'h2
`define QIO_CODE_SRC_B 2'h3
// ****************************************
// reset values
// ****************************************
`define QIO_CFG_RST 8'h00
`define QIO_LATCH_RST 8'h00
`define QIO_AUX_RST 8'h00
`define QIO_MODE_RST 4'h0
`define QIO_SNAP_RST 8'h00
// ****************************************
// timing
// ****************************************
`define QIO_CLK_PERIOD_NS 100
`define QIO_DET_PERIOD_NS 26040
`define QIO_DET_CYCLES (`QIO_DET_PERIOD_NS / `QIO_CLK_PERIOD_NS)
`define QIO_RESP_OKAY 2'h0
`define QIO_RESP_SLVERR 2'h2
`endif

// ### hw/qio_port.v
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "qio_defines.vh"
// What this block does
// [RL1] low nibble of each change register repeats low nibble of pin-level register
// [RL2] high nibble shows pin1/pin0 change flags of both channels, enabled by aux bits
// [RL3] one 8-bit config per channel, two bits per pin, pin3 on top
// [RL4] code 00 turns off the driver only; inputs always stay live
// [RL5] general output drives the inverse of its latch bit
// [RL6] latch bits are written at indices 0c and 1c, one per pair
// [RL7] pin-level register shows live pin level, input or output
// [RL8] pin levels sit in a fixed scrambled bit order
// [RL9] pin levels are not frozen for a read; clocks may read garbage
// [RL10] codes 01/10/11 select latch or fixed clock sources per pin
// [RL11] input functions always sample the pin, even when driven
// [RL12] detectors on pin0/pin1 follow the pin whatever drives it
// [RL13] pin3 code not 00 makes pin1 the transmit clock input
// [RL14] pin2 carries rts when code 01, handshake bit and latch bit set
// [RL15] pin1 carries rts when code 01, handshake bit and latch bit set
// [RL16] interrupt snapshot refreshes on acknowledge or refresh write at 2a
// [RL17] interrupt request alone never refreshes the snapshot
// [RL18] snapshot holds 3-bit count, 3-bit type, 2-bit channel
// [RL19] type codes pass through unchanged from the arbiter
// [RL20] reading a change register clears its change flags
// [RL21] detectors sample at 38.4 kHz, confirm after two samples (1 to 2 periods)
// [RL22] reset puts every pin into input mode
// [RL23] pins pass a synchroniser before any internal use
// [RL24] software sets config before use and avoids reading clock pins
module qio_port #(
  parameter DET_CYCLES = `QIO_DET_CYCLES
) (
  input wire sys_clk, // 10 MHz
  input wire rst, // sync, active high
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // byte enables
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire [15:0] pin_in, // pin levels, chan*4+pin
  output reg [15:0] pin_out, // pin drive value
  output reg [15:0] pin_oe, // pin drive enable
  input wire [3:0] transmit_clock_16x, // per channel
  input wire [3:0] transmit_clock_1x, // per channel
  input wire [3:0] receive_clock_16x, // per channel
  input wire [3:0] receive_clock_1x, // per channel
  input wire [1:0] counter_out, // counter/timer ab, cd
  input wire [3:0] request_to_send_n, // per channel
  output reg [3:0] clear_to_send_n, // to channels
  output reg [3:0] ext_transmit_clock, // to channels
  output reg [3:0] ext_receive_clock, // to channels
  output reg [1:0] counter_clock_in, // to counter ab, cd
  output reg [3:0] hs_enable, // mode_reg_one bit 7 copy, per channel
  input wire interrupt_ack_n, // acknowledge pin
  input wire [2:0] bid_count, // winning bid byte count
  input wire [2:0] bid_type, // winning bid type
  input wire [1:0] bid_chan // winning bid channel
);

// ****************************************
// helpers
// ****************************************
// pins {c1p3,c1p2,c1p1,c1p0,c0p3,c0p2,c0p1,c0p0} into register order
function [7:0] to_reg;
  input [7:0] p;
  begin
    to_reg = {p[7], p[6], p[3], p[2], p[5], p[4], p[1], p[0]}; // RL8
  end
endfunction

// register order back to per-pin order
function [7:0] to_pins;
  input [7:0] r;
  begin
    to_pins = {r[7], r[6], r[3], r[2], r[5], r[4], r[1], r[0]};
  end
endfunction

function [1:0] field;
  input [7:0] cfg;
  input [1:0] n;
  begin
    case (n)
      2'h0: field = cfg[`QIO_CFG_P0];
      2'h1: field = cfg[`QIO_CFG_P1];
      2'h2: field = cfg[`QIO_CFG_P2];
      default: field = cfg[`QIO_CFG_P3];
    endcase
  end
endfunction

// ****************************************
// state
// ****************************************
reg [7:0] cfg_q [0:3];
reg [7:0] latch_q [0:1];
reg [7:0] aux_q;
reg [3:0] mode_q;
reg [7:0] snap_q;
reg [7:0] chg_q [0:1];
reg [15:0] s1_q;
reg [15:0] s2_q;
reg [15:0] s3_q;
reg [15:0] lvl_q;
reg [2:0] ack_q;
reg ack_lvl_q;
reg [8:0] tick_cnt_q;
reg tick_q;
wire [7:0] ev_w;
reg aw_full_q;
reg w_full_q;
reg [7:0] aw_addr_q;
reg [7:0] w_data_q;
reg w_lane_q;

wire [15:0] latch_pins = {to_pins(latch_q[1]), to_pins(latch_q[0])};
wire wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;
wire [5:0] wr_idx = aw_addr_q[7:2];
wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
wire [5:0] rd_idx = s_axi_araddr[7:2];
wire ack_fall = ack_lvl_q & ~((ack_q[1] == ack_q[2]) ? ack_q[2] : ack_lvl_q);

assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
assign s_axi_wready = ~w_full_q & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;

// ****************************************
// pin synchronisers
// ****************************************
always @(posedge sys_clk) begin
  if (rst) begin
    s1_q <= 16'h0000;
    s2_q <= 16'h0000;
    s3_q <= 16'h0000;
    lvl_q <= 16'h0000;
    ack_q <= 3'h7;
    ack_lvl_q <= 1'b1;
  end else begin
    s1_q <= pin_in; // RL23
    s2_q <= s1_q;
    s3_q <= s2_q;
    // a change counts once stages two and three agree
    lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q)); // RL7 RL11
    ack_q <= {ack_q[1:0], interrupt_ack_n};
    if (ack_q[1] == ack_q[2]) begin
      ack_lvl_q <= ack_q[2];
    end
  end
end

// ****************************************
// change detectors
// ****************************************
always @(posedge sys_clk) begin
  if (rst) begin
    tick_cnt_q <= 9'h000;
    tick_q <= 1'b0;
  end else if (tick_cnt_q == DET_CYCLES - 1) begin
    tick_cnt_q <= 9'h000;
    tick_q <= 1'b1; // RL21
  end else begin
    tick_cnt_q <= tick_cnt_q + 9'h001;
    tick_q <= 1'b0;
  end
end

genvar k;
generate
  for (k = 0; k < 8; k = k + 1) begin : g_det
    // detector k watches channel k/2, pin k%2
    localparam integer PIN = (k / 2) * 4 + (k % 2);
    reg samp_q;
    reg stable_q;
    always @(posedge sys_clk) begin
      if (rst) begin
        samp_q <= 1'b0;
        stable_q <= 1'b0;
      end else if (tick_q) begin
        samp_q <= lvl_q[PIN]; // RL12
        // same new level on two samples: stable 1 to 2 periods
        if (samp_q == lvl_q[PIN] && stable_q != lvl_q[PIN]) begin
          stable_q <= lvl_q[PIN]; // RL21
        end
      end
    end
    assign ev_w[k] = tick_q & (samp_q == lvl_q[PIN]) & (stable_q != lvl_q[PIN]) & aux_q[k];
  end
endgenerate

// ****************************************
// pin drivers and channel inputs
// ****************************************
integer c;
integer n;
always @(posedge sys_clk) begin
  if (rst) begin
    pin_out <= 16'h0000;
    pin_oe <= 16'h0000; // RL22
    clear_to_send_n <= 4'hf;
    ext_transmit_clock <= 4'h0;
    ext_receive_clock <= 4'h0;
    counter_clock_in <= 2'h0;
  end else begin
    for (c = 0; c < 4; c = c + 1) begin
      for (n = 0; n < 4; n = n + 1) begin
        pin_oe[c * 4 + n] <= (field(cfg_q[c], n[1:0]) != `QIO_CODE_OFF); // RL4
        case (field(cfg_q[c], n[1:0]))
          `QIO_CODE_GEN: begin
            // rts may take over pins 1 and 2 when handshake is on
            if (n != 0 && n != 3 && mode_q[c] && latch_pins[c * 4 + n]) begin
              pin_out[c * 4 + n] <= request_to_send_n[c]; // RL14 RL15
            end else begin
              pin_out[c * 4 + n] <= ~latch_pins[c * 4 + n]; // RL5 RL10
            end
          end
          `QIO_CODE_SRC_A: begin
            case (n)
              0: pin_out[c * 4 + n] <= transmit_clock_1x[c]; // RL10
              1: pin_out[c * 4 + n] <= c[0] ? counter_out[c / 2] : receive_clock_16x[c];
              2: pin_out[c * 4 + n] <= receive_clock_1x[c];
              default: pin_out[c * 4 + n] <= transmit_clock_16x[c];
            endcase
          end
          `QIO_CODE_SRC_B: begin
            case (n)
              0: pin_out[c * 4 + n] <= transmit_clock_16x[c]; // RL10
              1: pin_out[c * 4 + n] <= receive_clock_1x[c];
              2: pin_out[c * 4 + n] <= receive_clock_16x[c];
              default: pin_out[c * 4 + n] <= transmit_clock_1x[c];
            endcase
          end
          default: pin_out[c * 4 + n] <= 1'b1;
        endcase
      end
      // inputs read the pin even while it is driven
      clear_to_send_n[c] <= lvl_q[c * 4]; // RL11
      ext_receive_clock[c] <= lvl_q[c * 4 + 2];
      if (cfg_q[c][`QIO_CFG_P3] != `QIO_CODE_OFF) begin
        ext_transmit_clock[c] <= lvl_q[c * 4 + 1]; // RL13
      end else begin
        ext_transmit_clock[c] <= lvl_q[c * 4 + 3];
      end
    end
    counter_clock_in <= {lvl_q[9], lvl_q[1]}; // RL11
  end
end

// ****************************************
// register writes
// ****************************************
integer i;
always @(posedge sys_clk) begin
  if (rst) begin
    for (i = 0; i < 4; i = i + 1) begin
      cfg_q[i] <= `QIO_CFG_RST; // RL22
    end
    latch_q[0] <= `QIO_LATCH_RST;
    latch_q[1] <= `QIO_LATCH_RST;
    aux_q <= `QIO_AUX_RST;
    mode_q <= `QIO_MODE_RST;
    snap_q <= `QIO_SNAP_RST;
    hs_enable <= `QIO_MODE_RST;
    aw_full_q <= 1'b0;
    w_full_q <= 1'b0;
    aw_addr_q <= 8'h00;
    w_data_q <= 8'h00;
    w_lane_q <= 1'b0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `QIO_RESP_OKAY;
  end else begin
    hs_enable <= mode_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata[7:0];
      w_lane_q <= s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
    if (wr_go) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= `QIO_RESP_OKAY;
      case (wr_idx)
        `QIO_IDX_LATCH_AB: if (w_lane_q) latch_q[0] <= w_data_q; // RL6
        `QIO_IDX_LATCH_CD: if (w_lane_q) latch_q[1] <= w_data_q; // RL6
        `QIO_IDX_AUX: if (w_lane_q) aux_q <= w_data_q;
        `QIO_IDX_MODE: if (w_lane_q) mode_q <= w_data_q[3:0];
        `QIO_IDX_REFRESH: ;
        `QIO_IDX_CFG_A, `QIO_IDX_CFG_A + 6'h01, `QIO_IDX_CFG_A + 6'h02,
        `QIO_IDX_CFG_A + 6'h03: begin
          if (w_lane_q) cfg_q[wr_idx[1:0]] <= w_data_q; // RL3
        end
        default: s_axi_bresp <= `QIO_RESP_SLVERR;
      endcase
    end
    // only acknowledge or the refresh write move the snapshot, never the request
    if (ack_fall || (wr_go && wr_idx == `QIO_IDX_REFRESH)) begin
      snap_q <= {bid_count, bid_type, bid_chan}; // RL16 RL17 RL18 RL19
    end
  end
end

// ****************************************
// change flags: set wins over read clear
// ****************************************
always @(posedge sys_clk) begin
  if (rst) begin
    chg_q[0] <= 8'h00;
    chg_q[1] <= 8'h00;
  end else begin
    chg_q[0] <= ((rd_go && rd_idx == `QIO_IDX_CHG_AB) ? 8'h00 : chg_q[0])
      | {ev_w[3:0], 4'h0}; // RL2 RL20
    chg_q[1] <= ((rd_go && rd_idx == `QIO_IDX_CHG_CD) ? 8'h00 : chg_q[1])
      | {ev_w[7:4], 4'h0}; // RL2 RL20
  end
end

// ****************************************
// register reads
// ****************************************
wire [7:0] lvl_ab = to_reg(lvl_q[7:0]); // RL8 RL9
wire [7:0] lvl_cd = to_reg(lvl_q[15:8]);
always @(posedge sys_clk) begin
  if (rst) begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h00000000;
    s_axi_rresp <= `QIO_RESP_OKAY;
  end else begin
    if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
    if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `QIO_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      case (rd_idx)
        `QIO_IDX_CHG_AB: s_axi_rdata[7:0] <= {chg_q[0][7:4], lvl_ab[3:0]}; // RL1 RL2
        `QIO_IDX_CHG_CD: s_axi_rdata[7:0] <= {chg_q[1][7:4], lvl_cd[3:0]}; // RL1 RL2
        `QIO_IDX_LVL_AB: s_axi_rdata[7:0] <= lvl_ab; // RL7
        `QIO_IDX_LVL_CD: s_axi_rdata[7:0] <= lvl_cd; // RL7
        `QIO_IDX_LATCH_AB, `QIO_IDX_LATCH_CD: ;
        `QIO_IDX_SNAP: s_axi_rdata[7:0] <= snap_q; // RL18
        `QIO_IDX_SNAP_CHAN: s_axi_rdata[7:0] <= {6'h00, snap_q[`QIO_SNAP_CHAN]};
        `QIO_IDX_REFRESH: s_axi_rdata[7:0] <= {5'h00, snap_q[`QIO_SNAP_CNT]};
        `QIO_IDX_AUX: s_axi_rdata[7:0] <= aux_q;
        `QIO_IDX_MODE: s_axi_rdata[7:0] <= {4'h0, mode_q};
        `QIO_IDX_CFG_A, `QIO_IDX_CFG_A + 6'h01, `QIO_IDX_CFG_A + 6'h02,
        `QIO_IDX_CFG_A + 6'h03: begin
          s_axi_rdata[7:0] <= cfg_q[rd_idx[1:0]]; // RL3
        end
        default: s_axi_rresp <= `QIO_RESP_SLVERR;
      endcase
    end
  end
end

endmodule

// ### sim/qio_port_props.sv
`timescale 1ns/1ns
`include "qio_defines.vh"
module qio_port_props #(
  parameter DET_CYCLES = `QIO_DET_CYCLES
) (
  input wire sys_clk, // clock
  input wire rst, // reset
  input wire s_axi_awready, // aw ready
  input wire s_axi_wready, // w ready
  input wire s_axi_bvalid, // b valid
  input wire s_axi_bready, // b ready
  input wire [1:0] s_axi_bresp, // b resp
  input wire s_axi_arready, // ar ready
  input wire [31:0] s_axi_rdata, // r data
  input wire s_axi_rvalid, // r valid
  input wire s_axi_rready, // r ready
  input wire [15:0] pin_in, // pin levels
  input wire [15:0] pin_oe, // drive enables
  input wire [3:0] clear_to_send_n, // cts to channels
  input wire [3:0] ext_receive_clock, // rx clock to channels
  input wire [1:0] counter_clock_in // counter clocks
);
  // ****
  // bus and pin properties
  // ****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_bhold;
    s_axi_bvalid |=> (s_axi_bvalid && $stable(s_axi_bresp)) || $past(s_axi_bready);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold;
    s_axi_rvalid |=> (s_axi_rvalid && $stable(s_axi_rdata)) || $past(s_axi_rready);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  property p_rtop;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rtop: assert property (p_rtop) else $error("read data upper bits set");
  property p_wbusy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wbusy: assert property (p_wbusy) else $error("new write taken before response");
  property p_rbusy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rbusy: assert property (p_rbusy) else $error("new read taken before data");
  property p_rstoff;
    $fell(rst) |-> pin_oe == 16'h0;
  endproperty
  a_rstoff: assert property (p_rstoff) else $error("pins driven after reset");
  // settled pins must reach input functions even when driven
  property p_cts;
    ($stable(pin_in[0]))[*7] |-> clear_to_send_n[0] == pin_in[0];
  endproperty
  a_cts: assert property (p_cts) else $error("cts not following pin");
  property p_rxc;
    ($stable(pin_in[6]))[*7] |-> ext_receive_clock[1] == pin_in[6];
  endproperty
  a_rxc: assert property (p_rxc) else $error("rx clock not following pin");
  property p_ctr;
    ($stable(pin_in[9]))[*7] |-> counter_clock_in[1] == pin_in[9];
  endproperty
  a_ctr: assert property (p_ctr) else $error("counter clock not following pin");
endmodule
bind qio_port qio_port_props #(.DET_CYCLES(DET_CYCLES)) u_props (
  .sys_clk(sys_clk), .rst(rst), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pin_in(pin_in), .pin_oe(pin_oe),
  .clear_to_send_n(clear_to_send_n), .ext_receive_clock(ext_receive_clock),
  .counter_clock_in(counter_clock_in)
);

// ### sim/qio_pins_model.sv
`timescale 1ns/1ns
module qio_pins_model (
  input wire [15:0] pin_out, // design drive value
  input wire [15:0] pin_oe, // design drive enable
  input wire [15:0] ext_drive, // far side level
  output wire [15:0] pin_in // wire level
);
  // ****
  // wire resolution
  // ****
  // far side lets go of a pin the design drives, so the pin loops back
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive);
endmodule

// ### sim/qio_port_tb.sv
`timescale 1ns/1ns
`include "qio_defines.vh"
module qio_port_tb;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] awaddr = 8'h0, araddr = 8'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg [15:0] ext = 16'h0;
  reg [3:0] tx16 = 4'h0, tx1 = 4'h0, rx16 = 4'h0, rx1 = 4'h0, rts_n = 4'hf;
  reg [1:0] ctr = 2'h0, bch = 2'h0;
  reg [2:0] bc = 3'h0, bt = 3'h0;
  reg ack_n = 1'b1;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp, cci;
  wire [31:0] rdata;
  wire [15:0] pin_in, pin_out, pin_oe;
  wire [3:0] cts_n, etx, erx, hs;
  integer miscompares = 0, comparisons = 0, c, n;
  reg [1:0] wq[$];
  reg [9:0] rq[$];
  reg [7:0] e;
  always #50 sys_clk = ~sys_clk;
  qio_port #(.DET_CYCLES(4)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .transmit_clock_16x(tx16),
    .transmit_clock_1x(tx1), .receive_clock_16x(rx16), .receive_clock_1x(rx1),
    .counter_out(ctr), .request_to_send_n(rts_n), .clear_to_send_n(cts_n),
    .ext_transmit_clock(etx), .ext_receive_clock(erx), .counter_clock_in(cci),
    .hs_enable(hs), .interrupt_ack_n(ack_n), .bid_count(bc), .bid_type(bt), .bid_chan(bch)
  );
  qio_pins_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drive(ext), .pin_in(pin_in));
  // ****
  // checking and bus tasks
  // ****
  task cmp(input [31:0] exp, input [31:0] got);
    begin
      comparisons = comparisons + 1;
      if (exp !== got) begin
        miscompares = miscompares + 1;
        $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
      end
    end
  endtask
  task cmp_resp(input [1:0] exp, input [1:0] got);
    cmp({30'h0, exp}, {30'h0, got});
  endtask
  task cmp_read(input [9:0] exp, input [9:0] got);
    cmp({22'h0, exp}, {22'h0, got});
  endtask
  task cmp_pins(input [15:0] exp, input [15:0] got);
    cmp({16'h0, exp}, {16'h0, got});
  endtask
  task end_of_test;
    begin
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  task wr(input [5:0] i, input [7:0] d, input [1:0] er);
    reg a, dw, b;
    integer k, r;
    begin
      wq.push_back(er);
      @(posedge sys_clk);
      r = $urandom;
      awaddr <= {i, 2'b00};
      wdata <= {r[23:0], d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      a = 1'b1;
      dw = 1'b1;
      b = 1'b1;
      for (k = 0; k < 50 && b; k = k + 1) begin
        @(posedge sys_clk);
        if (a && awready) begin
          a = 1'b0;
          awvalid <= 1'b0;
        end
        if (dw && wready) begin
          dw = 1'b0;
          wvalid <= 1'b0;
        end
        if (bvalid) begin
          b = 1'b0;
          bready <= 1'b0;
        end
      end
      if (b) begin
        miscompares = miscompares + 1;
        end_of_test;
      end
    end
  endtask
  task rd(input [5:0] i, input [7:0] d, input [1:0] er);
    reg a, b;
    integer k;
    begin
      rq.push_back({er, d});
      @(posedge sys_clk);
      araddr <= {i, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      a = 1'b1;
      b = 1'b1;
      for (k = 0; k < 50 && b; k = k + 1) begin
        @(posedge sys_clk);
        if (a && arready) begin
          a = 1'b0;
          arvalid <= 1'b0;
        end
        if (rvalid) begin
          b = 1'b0;
          rready <= 1'b0;
        end
      end
      if (b) begin
        miscompares = miscompares + 1;
        end_of_test;
      end
    end
  endtask
  always @(posedge sys_clk) begin
    if (bvalid && bready) cmp_resp(wq.pop_front(), bresp);
    if (rvalid && rready) cmp_read(rq.pop_front(), {rresp, rdata[7:0]});
  end
  // ****
  // main sequence
  // ****
  initial begin
    n = $urandom(32'h86ef20f4);
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    for (c = 0; c < 4; c = c + 1) rd(`QIO_IDX_CFG_A + c[5:0], 8'h00, 2'h0);
    n = $urandom;
    ext <= n[15:0];
    e = n[23:16];
    wr(`QIO_IDX_CFG_A, 8'h55, 2'h0);
    rd(`QIO_IDX_CFG_A, 8'h55, 2'h0);
    wr(`QIO_IDX_LATCH_AB, e, 2'h0);
    rd(`QIO_IDX_LATCH_AB, 8'h00, 2'h0);
    repeat (6) @(posedge sys_clk);
    cmp_pins({4'hf, ~e[5], ~e[4], ~e[1], ~e[0]}, {pin_oe[3:0], pin_out[3:0]});
    rd(`QIO_IDX_LVL_AB, {ext[7:6], ~e[5:4], ext[5:4], ~e[1:0]}, 2'h0);
    rd(`QIO_IDX_LVL_CD, {ext[15:14], ext[11:10], ext[13:12], ext[9:8]}, 2'h0);
    n = $urandom;
    rts_n <= n[3:0];
    wr(`QIO_IDX_MODE, 8'h01, 2'h0);
    wr(`QIO_IDX_LATCH_AB, 8'h12, 2'h0);
    repeat (3) @(posedge sys_clk);
    cmp_pins({4'h1, 1'b1, rts_n[0], rts_n[0], 1'b1}, {hs, pin_out[3:0]});
    wr(`QIO_IDX_MODE, 8'h00, 2'h0);
    for (c = 2; c < 4; c = c + 1) begin
      n = $urandom;
      {tx16, tx1, rx16, rx1, ctr} <= n[17:0];
      wr(`QIO_IDX_CFG_A, {4{c[1:0]}}, 2'h0);
      wr(`QIO_IDX_CFG_A + 6'h01, {4{c[1:0]}}, 2'h0);
      repeat (3) @(posedge sys_clk);
      if (c == 2) begin
        cmp_pins({tx16[1], rx1[1], ctr[0], tx1[1], tx16[0], rx1[0], rx16[0], tx1[0]},
          pin_out[7:0]);
      end else begin
        cmp_pins({tx1[1], rx16[1], rx1[1], tx16[1], tx1[0], rx16[0], rx1[0], tx16[0]},
          pin_out[7:0]);
      end
    end
    ext <= 16'h0002;
    wr(`QIO_IDX_CFG_A, 8'hc0, 2'h0);
    wr(`QIO_IDX_CFG_A + 6'h01, 8'h00, 2'h0);
    repeat (6) @(posedge sys_clk);
    cmp_pins({8'h08, 1'b1, 1'b1, 1'b0}, {pin_oe[7:0], etx[0], cci[0], cts_n[0]});
    wr(`QIO_IDX_CFG_A, 8'h00, 2'h0);
    repeat (30) @(posedge sys_clk);
    cmp_pins({4'h0, 1'b0}, {pin_oe[3:0], etx[0]});
    wr(`QIO_IDX_AUX, 8'h01, 2'h0);
    rd(`QIO_IDX_CHG_AB, 8'h02, 2'h0);
    ext <= 16'h0013;
    repeat (30) @(posedge sys_clk);
    rd(`QIO_IDX_CHG_AB, 8'h17, 2'h0);
    rd(`QIO_IDX_CHG_AB, 8'h07, 2'h0);
    rd(`QIO_IDX_CHG_CD, 8'h00, 2'h0);
    for (c = 0; c < 8; c = c + 1) begin
      n = $urandom;
      bt <= c[2:0];
      {bc, bch} <= n[4:0];
      wr(`QIO_IDX_REFRESH, 8'h00, 2'h0);
      rd(`QIO_IDX_SNAP, {n[4:2], c[2:0], n[1:0]}, 2'h0);
    end
    e = {n[4:2], 3'h7, n[1:0]};
    n = $urandom;
    {bc, bt, bch} <= n[7:0];
    rd(`QIO_IDX_SNAP, e, 2'h0);
    rd(`QIO_IDX_SNAP_CHAN, {6'h0, e[1:0]}, 2'h0);
    rd(`QIO_IDX_REFRESH, {5'h0, e[7:5]}, 2'h0);
    ack_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    ack_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd(`QIO_IDX_SNAP, n[7:0], 2'h0);
    wr(6'h3f, 8'h5a, `QIO_RESP_SLVERR);
    rd(6'h3f, 8'h00, `QIO_RESP_SLVERR);
    repeat (4) @(posedge sys_clk);
    end_of_test;
  end
endmodule
